// file: dmv_core.sv
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "dmv_map.svh"
// Functional notes
// - copy_file_register reads file f (0..127) and writes it to the accumulator when d=0 or back to f when d=1.
// - copy_file_register updates result_null_flag from the moved value.
// - indirect_load_to_accumulator reads memory at the selected pointer (0 or 1) into the accumulator and updates the flag.
// - pre-modify modes 00/01 step the pointer by one first and use the new value as the address.
// - post-modify modes 10/11 use the current pointer and then step it by one.
// - relative form uses pointer plus a signed offset -32..31 and leaves the pointer alone.
// - the pointer is 16 bits and wraps at 0000h and FFFFh.
// - load_bank_literal loads a 5-bit value into bank_select_register, flags untouched.
// - load_page_literal loads a 7-bit value into program_counter_latch_high, flags untouched.
// - load_literal_to_accumulator loads an 8-bit value into the accumulator, flags untouched.
// - store_accumulator_to_file writes the accumulator to file f (0..127), flags untouched.
module dmv_core
  import dmv_pkg::*;
#(
  parameter int AW = `DMV_ADDR_W,
  parameter int PW = `DMV_PTR_W,
  parameter int DW = `DMV_DATA_W
) (
  input  wire logic               CLK,        // clock, 250 MHz
  input  wire logic               SYS_RST,    // sync reset, active high
  input  wire logic               INSTR_VALID,// one-cycle instruction strobe
  input  wire dmv_pkg::dmv_op_t   INSTR_OP,   // instruction kind
  input  wire logic [AW-1:0]      INSTR_FILE, // file address operand
  input  wire logic               INSTR_DEST, // 0 accumulator, 1 file
  input  wire logic               INSTR_PSEL, // pointer index
  input  wire logic [1:0]         INSTR_MODE, // pre/post modify mode
  input  wire logic [5:0]         INSTR_OFS,  // signed offset
  input  wire logic [7:0]         INSTR_LIT,  // literal operand
  output logic                    BUSY,       // instruction in progress
  output logic                    DONE,       // one-cycle completion pulse
  output logic                    MEM_RD,     // data memory read strobe
  output logic                    MEM_WR,     // data memory write strobe
  output logic [PW-1:0]           MEM_ADDR,   // data memory address
  output logic [DW-1:0]           MEM_WDATA,  // data memory write data
  input  wire logic [DW-1:0]      MEM_RDATA,  // read data, cycle after MEM_RD
  output logic [DW-1:0]           ACC,        // accumulator
  output logic                    NULL_FLAG,  // result_null_flag
  output logic [`DMV_BANK_W-1:0]  BANK_SEL,   // bank_select_register
  output logic [`DMV_PAGE_W-1:0]  PAGE_HI,    // program_counter_latch_high
  output logic [PW-1:0]           PTR0,       // indirect pointer 0
  output logic [PW-1:0]           PTR1        // indirect pointer 1
);
  import dmv_pkg::*;

  dmv_state_t          st_q, st_d;
  dmv_op_t             op_q, op_d;
  logic                dest_q, dest_d;
  logic [AW-1:0]       file_q, file_d;
  logic                rd_q, rd_d;
  logic                wr_q, wr_d;
  logic                done_q, done_d;
  logic [PW-1:0]       addr_q, addr_d;
  logic [DW-1:0]       wdata_q, wdata_d;
  logic [DW-1:0]       acc_q, acc_d;
  logic                flag_q, flag_d;
  logic [`DMV_BANK_W-1:0] bank_q, bank_d;
  logic [`DMV_PAGE_W-1:0] page_q, page_d;
  logic [PW-1:0]       ptr0_q, ptr0_d;
  logic [PW-1:0]       ptr1_q, ptr1_d;
  logic [PW-1:0]       sel_ptr;
  logic [PW-1:0]       eff_addr;
  logic [PW-1:0]       ptr_next;
  logic                rd_zero;
  logic                busy_q, busy_d;

  dmv_ptr_unit #(.PW(PW)) u_ptr (
    .ptr      (sel_ptr),
    .mode     (INSTR_MODE),
    .rel      (INSTR_OP == DMV_OP_IND_LOAD_REL),
    .ofs      (INSTR_OFS),
    .eff_addr (eff_addr),
    .ptr_next (ptr_next)
  );

  dmv_flag_unit #(.DW(DW)) u_flag (
    .value (MEM_RDATA),
    .zero  (rd_zero)
  );

  // file registers live in data memory; bank bits are not applied here
  function automatic logic [PW-1:0] file_addr(input logic [AW-1:0] f);
    file_addr = {{(PW-AW){1'b0}}, f};
  endfunction

  // own assign keeps the pointer unit out of the next-state process loop
  assign sel_ptr = INSTR_PSEL ? ptr1_q : ptr0_q;

  always_comb
  begin
    st_d    = st_q;
    op_d    = op_q;
    dest_d  = dest_q;
    file_d  = file_q;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    done_d  = 1'b0;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    acc_d   = acc_q;
    flag_d  = flag_q;
    bank_d  = bank_q;
    page_d  = page_q;
    ptr0_d  = ptr0_q;
    ptr1_d  = ptr1_q;
    case (st_q)
      DMV_ST_IDLE:
      begin
        if (INSTR_VALID)
        begin
          op_d   = INSTR_OP;
          dest_d = INSTR_DEST;
          file_d = INSTR_FILE;
          case (INSTR_OP)
            DMV_OP_COPY_FILE:
            begin
              rd_d   = 1'b1;
              addr_d = file_addr(INSTR_FILE);
              st_d   = DMV_ST_READ;
            end
            DMV_OP_IND_LOAD, DMV_OP_IND_LOAD_REL:
            begin
              rd_d   = 1'b1;
              addr_d = eff_addr;
              if (INSTR_PSEL)
                ptr1_d = ptr_next;
              else
                ptr0_d = ptr_next;
              st_d   = DMV_ST_READ;
            end
            DMV_OP_LOAD_BANK:
            begin
              bank_d = INSTR_LIT[`DMV_BANK_W-1:0];
              done_d = 1'b1;
            end
            DMV_OP_LOAD_PAGE:
            begin
              page_d = INSTR_LIT[`DMV_PAGE_W-1:0];
              done_d = 1'b1;
            end
            DMV_OP_LOAD_ACC:
            begin
              acc_d  = INSTR_LIT;
              done_d = 1'b1;
            end
            DMV_OP_STORE_ACC:
            begin
              wr_d    = 1'b1;
              addr_d  = file_addr(INSTR_FILE);
              wdata_d = acc_q;
              done_d  = 1'b1;
            end
            default: done_d = 1'b0;
          endcase
        end
      end
      DMV_ST_READ:
      begin
        // memory answers one cycle after the read strobe
        st_d = DMV_ST_DONE;
      end
      DMV_ST_DONE:
      begin
        flag_d = rd_zero;
        done_d = 1'b1;
        st_d   = DMV_ST_IDLE;
        if (op_q == DMV_OP_COPY_FILE && dest_q)
        begin
          wr_d    = 1'b1;
          addr_d  = file_addr(file_q);
          wdata_d = MEM_RDATA;
        end
        else
        begin
          acc_d = MEM_RDATA;
        end
      end
      default: st_d = DMV_ST_IDLE;
    endcase
    // registered so the busy output comes straight from a flip-flop
    busy_d = (st_d != DMV_ST_IDLE);
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      st_q    <= DMV_ST_IDLE;
      op_q    <= DMV_OP_NONE;
      dest_q  <= 1'b0;
      file_q  <= '0;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      done_q  <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
      acc_q   <= `DMV_ACC_RST;
      flag_q  <= 1'b0;
      bank_q  <= `DMV_BANK_RST;
      page_q  <= `DMV_PAGE_RST;
      ptr0_q  <= `DMV_PTR_RST;
      ptr1_q  <= `DMV_PTR_RST;
      busy_q  <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      op_q    <= op_d;
      dest_q  <= dest_d;
      file_q  <= file_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      done_q  <= done_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      acc_q   <= acc_d;
      flag_q  <= flag_d;
      bank_q  <= bank_d;
      page_q  <= page_d;
      ptr0_q  <= ptr0_d;
      ptr1_q  <= ptr1_d;
      busy_q  <= busy_d;
    end
  end

  assign BUSY      = busy_q;
  assign DONE      = done_q;
  assign MEM_RD    = rd_q;
  assign MEM_WR    = wr_q;
  assign MEM_ADDR  = addr_q;
  assign MEM_WDATA = wdata_q;
  assign ACC       = acc_q;
  assign NULL_FLAG = flag_q;
  assign BANK_SEL  = bank_q;
  assign PAGE_HI   = page_q;
  assign PTR0      = ptr0_q;
  assign PTR1      = ptr1_q;

  // helper: is the instruction taken this cycle a flag-preserving one
  logic keep_flag;
  assign keep_flag = INSTR_VALID && !BUSY &&
    (INSTR_OP == DMV_OP_LOAD_BANK || INSTR_OP == DMV_OP_LOAD_PAGE ||
     INSTR_OP == DMV_OP_LOAD_ACC || INSTR_OP == DMV_OP_STORE_ACC);

  sequence s_read_issue;
    INSTR_VALID && !BUSY && (INSTR_OP == DMV_OP_IND_LOAD || INSTR_OP == DMV_OP_COPY_FILE);
  endsequence

  property p_flag_keep;
    @(posedge CLK) disable iff (SYS_RST) keep_flag |=> $stable(NULL_FLAG);
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag changed by literal/store");

  property p_bank_load;
    @(posedge CLK) disable iff (SYS_RST)
      INSTR_VALID && !BUSY && INSTR_OP == DMV_OP_LOAD_BANK |=> BANK_SEL == $past(INSTR_LIT[4:0]);
  endproperty
  a_bank_load: assert property (p_bank_load) else $error("bank select not loaded");

  property p_page_load;
    @(posedge CLK) disable iff (SYS_RST)
      INSTR_VALID && !BUSY && INSTR_OP == DMV_OP_LOAD_PAGE |=> PAGE_HI == $past(INSTR_LIT[6:0]);
  endproperty
  a_page_load: assert property (p_page_load) else $error("page latch not loaded");

  property p_acc_lit;
    @(posedge CLK) disable iff (SYS_RST)
      INSTR_VALID && !BUSY && INSTR_OP == DMV_OP_LOAD_ACC |=> ACC == $past(INSTR_LIT) && DONE;
  endproperty
  a_acc_lit: assert property (p_acc_lit) else $error("accumulator literal wrong");

  property p_store;
    @(posedge CLK) disable iff (SYS_RST)
      INSTR_VALID && !BUSY && INSTR_OP == DMV_OP_STORE_ACC
      |=> MEM_WR && MEM_WDATA == $past(ACC) && MEM_ADDR == {9'h000, $past(INSTR_FILE)};
  endproperty
  a_store: assert property (p_store) else $error("store to file wrong");

  property p_read_done;
    @(posedge CLK) disable iff (SYS_RST) s_read_issue |=> MEM_RD ##2 DONE;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read sequence timing wrong");

  property p_zero_flag;
    @(posedge CLK) disable iff (SYS_RST)
      BUSY && $past(BUSY) |=> NULL_FLAG == ($past(MEM_RDATA) == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_postinc;
    @(posedge CLK) disable iff (SYS_RST)
      INSTR_VALID && !BUSY && INSTR_OP == DMV_OP_IND_LOAD && !INSTR_PSEL && INSTR_MODE == 2'h2
      |=> MEM_ADDR == $past(PTR0) && PTR0 == $past(PTR0) + 16'h0001;
  endproperty
  a_postinc: assert property (p_postinc) else $error("post increment wrong");

  property p_predec;
    @(posedge CLK) disable iff (SYS_RST)
      INSTR_VALID && !BUSY && INSTR_OP == DMV_OP_IND_LOAD && INSTR_PSEL && INSTR_MODE == 2'h1
      |=> MEM_ADDR == $past(PTR1) - 16'h0001 && PTR1 == MEM_ADDR;
  endproperty
  a_predec: assert property (p_predec) else $error("pre decrement wrong");

  property p_rel;
    @(posedge CLK) disable iff (SYS_RST)
      INSTR_VALID && !BUSY && INSTR_OP == DMV_OP_IND_LOAD_REL && !INSTR_PSEL
      |=> PTR0 == $past(PTR0) && MEM_ADDR == $past(PTR0) + {{10{$past(INSTR_OFS[5])}}, $past(INSTR_OFS)};
  endproperty
  a_rel: assert property (p_rel) else $error("relative offset wrong");
endmodule // dmv_core

// file: dmv_map.svh
`ifndef DMV_MAP_SVH
`define DMV_MAP_SVH
// opcode field layout and reset values
`define DMV_OP_W        4
`define DMV_ADDR_W      7
`define DMV_PTR_W       16
`define DMV_DATA_W      8
`define DMV_BANK_W      5
`define DMV_PAGE_W      7
`define DMV_OFS_W       6
`define DMV_MODE_PREINC 2'h0
`define DMV_MODE_PREDEC 2'h1
`define DMV_MODE_POSTINC 2'h2
`define DMV_MODE_POSTDEC 2'h3
`define DMV_ACC_RST     8'h00
`define DMV_PTR_RST     16'h0000
`define DMV_BANK_RST    5'h00
`define DMV_PAGE_RST    7'h00
`define DMV_OFS_MIN     -32
`define DMV_OFS_MAX     31
// register port offsets
`define DMV_REG_ACC     4'h0
`define DMV_REG_FLAG    4'h1
`define DMV_REG_BANK    4'h2
`define DMV_REG_PAGE    4'h3
`define DMV_REG_PTR0    4'h4
`define DMV_REG_PTR1    4'h5
`endif

// file: dmv_pkg.sv
package dmv_pkg;
  typedef enum logic [2:0] {
    DMV_OP_NONE,
    DMV_OP_COPY_FILE,
    DMV_OP_IND_LOAD,
    DMV_OP_IND_LOAD_REL,
    DMV_OP_LOAD_BANK,
    DMV_OP_LOAD_PAGE,
    DMV_OP_LOAD_ACC,
    DMV_OP_STORE_ACC
  } dmv_op_t;
  typedef enum logic [1:0] {
    DMV_ST_IDLE,
    DMV_ST_READ,
    DMV_ST_DONE
  } dmv_state_t;
endpackage

// file: dmv_ptr_unit.sv
`timescale 1ns/1ns
`include "dmv_map.svh"
// effective address and pointer update for indirect loads
module dmv_ptr_unit
  import dmv_pkg::*;
#(
  parameter int PW = `DMV_PTR_W
) (
  input  wire logic [PW-1:0] ptr,      // current pointer
  input  wire logic [1:0]    mode,     // modify mode
  input  wire logic          rel,      // relative offset form
  input  wire logic [5:0]    ofs,      // signed offset
  output logic      [PW-1:0] eff_addr, // address used
  output logic      [PW-1:0] ptr_next  // pointer after instruction
);
  logic [PW-1:0] inc;
  logic [PW-1:0] dec;
  logic [PW-1:0] sofs;
  always_comb
  begin
    // modulo arithmetic gives the wrap at both ends
    inc  = ptr + {{(PW-1){1'b0}}, 1'b1};
    dec  = ptr - {{(PW-1){1'b0}}, 1'b1};
    sofs = {{(PW-6){ofs[5]}}, ofs};
    eff_addr = ptr;
    ptr_next = ptr;
    if (rel)
    begin
      eff_addr = ptr + sofs;
    end
    else
    begin
      case (mode)
        `DMV_MODE_PREINC:
        begin
          eff_addr = inc;
          ptr_next = inc;
        end
        `DMV_MODE_PREDEC:
        begin
          eff_addr = dec;
          ptr_next = dec;
        end
        `DMV_MODE_POSTINC: ptr_next = inc;
        `DMV_MODE_POSTDEC: ptr_next = dec;
        default: ptr_next = ptr;
      endcase
    end
  end
endmodule // dmv_ptr_unit

// file: dmv_flag_unit.sv
`timescale 1ns/1ns
`include "dmv_map.svh"
// zero detect on a moved byte
module dmv_flag_unit
  import dmv_pkg::*;
#(
  parameter int DW = `DMV_DATA_W
) (
  input  wire logic [DW-1:0] value, // moved value
  output logic               zero   // high when value is zero
);
  always_comb
  begin
    zero = (value == '0);
  end
endmodule // dmv_flag_unit

// file: dmv_core_test.sv
`timescale 1ns/1ns
module dmv_core_test;
  import dmv_pkg::*;

  logic        clk     = 1'b0;
  logic        sys_rst = 1'b1;
  logic        ivalid  = 1'b0;
  dmv_op_t     iop     = DMV_OP_NONE;
  logic [6:0]  ifile   = 7'h00;
  logic        idest   = 1'b0;
  logic        ipsel   = 1'b0;
  logic [1:0]  imode   = 2'h0;
  logic [5:0]  iofs    = 6'h00;
  logic [7:0]  ilit    = 8'h00;
  logic [7:0]  rdata   = 8'h00;
  logic        busy, done, mem_rd, mem_wr, null_flag;
  logic [15:0] mem_addr, ptr0, ptr1;
  logic [15:0] rd_addr = 16'h0000;
  logic [15:0] wr_addr = 16'h0000;
  logic [7:0]  wdata, acc;
  logic [7:0]  wr_data = 8'h00;
  logic [4:0]  bank;
  logic [6:0]  page;
  logic [15:0] mp [2];
  logic [7:0]  macc;
  logic        mflag;
  int          bad_count    = 0;
  int          total_checks = 0;
  int          wr_n         = 0;
  int          n0;

  always #2 clk = ~clk;

  dmv_core i_dut (
    .CLK         (clk),
    .SYS_RST     (sys_rst),
    .INSTR_VALID (ivalid),
    .INSTR_OP    (iop),
    .INSTR_FILE  (ifile),
    .INSTR_DEST  (idest),
    .INSTR_PSEL  (ipsel),
    .INSTR_MODE  (imode),
    .INSTR_OFS   (iofs),
    .INSTR_LIT   (ilit),
    .BUSY        (busy),
    .DONE        (done),
    .MEM_RD      (mem_rd),
    .MEM_WR      (mem_wr),
    .MEM_ADDR    (mem_addr),
    .MEM_WDATA   (wdata),
    .MEM_RDATA   (rdata),
    .ACC         (acc),
    .NULL_FLAG   (null_flag),
    .BANK_SEL    (bank),
    .PAGE_HI     (page),
    .PTR0        (ptr0),
    .PTR1        (ptr1)
  );

  // memory contents are a fold of the address; zero at 001f and ffe0
  function automatic logic [7:0] memv(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h1f;
  endfunction

  // read data only in the cycle after the strobe, toggling otherwise
  always @(posedge clk)
  begin
    rdata <= mem_rd ? memv(mem_addr) : ~rdata;
    if (mem_rd)
      rd_addr <= mem_addr;
    if (mem_wr)
    begin
      wr_addr <= mem_addr;
      wr_data <= wdata;
      wr_n    <= wr_n + 1;
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one instruction, then wait for completion and let any write land
  task automatic issue(input dmv_op_t op, input logic [6:0] f, input logic d,
                       input logic ps, input logic [1:0] m, input logic [5:0] o,
                       input logic [7:0] k);
    int n;
    logic rd_op;
    rd_op = (op == DMV_OP_COPY_FILE) || (op == DMV_OP_IND_LOAD) ||
            (op == DMV_OP_IND_LOAD_REL);
    @(posedge clk);
    ivalid <= 1'b1;
    iop    <= op;
    ifile  <= f;
    idest  <= d;
    ipsel  <= ps;
    imode  <= m;
    iofs   <= o;
    ilit   <= k;
    @(posedge clk);
    ivalid <= 1'b0;
    n = 0;
    #1;
    chk("busy", {15'h0, busy}, {15'h0, rd_op});
    while (done !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("done", {15'h0, done}, 16'h0001);
    chk("done_lat", 16'(n), rd_op ? 16'h0002 : 16'h0000);
    @(posedge clk);
    #1;
    chk("done_pulse", {15'h0, done}, 16'h0000);
  endtask

  task automatic regs(input string what);
    chk({what, "_acc"}, {8'h0, acc}, {8'h0, macc});
    chk({what, "_flag"}, {15'h0, null_flag}, {15'h0, mflag});
    chk({what, "_ptr0"}, ptr0, mp[0]);
    chk({what, "_ptr1"}, ptr1, mp[1]);
  endtask

  task automatic ind(input logic ps, input logic r, input logic [1:0] m, input logic [5:0] o);
    logic [15:0] p;
    logic [15:0] eff;
    p = mp[ps];
    if (r)
      eff = p + {{10{o[5]}}, o};
    else
      eff = (m == 2'h0) ? p + 16'h1 : (m == 2'h1) ? p - 16'h1 : p;
    if (!r)
      mp[ps] = m[0] ? p - 16'h1 : p + 16'h1;
    issue(r ? DMV_OP_IND_LOAD_REL : DMV_OP_IND_LOAD, 7'h00, 1'b0, ps, m, o, 8'h00);
    chk("ind_addr", rd_addr, eff);
    macc  = memv(eff);
    mflag = (macc == 8'h00);
    regs("ind");
  endtask

  initial
  begin
    #20000;
    bad_count++;
    $display("ERROR watchdog expected completion seen hang");
    report_and_stop();
  end

  initial
  begin
    mp[0] = 16'h0000;
    mp[1] = 16'h0000;
    macc  = 8'h00;
    mflag = 1'b0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    regs("reset");
    chk("reset_bank", {11'h0, bank}, 16'h0000);
    chk("reset_page", {9'h0, page}, 16'h0000);
    $display("test reset done");

    // copy onto itself as a zero test: written back, accumulator kept
    n0 = wr_n;
    mflag = 1'b1;
    issue(DMV_OP_COPY_FILE, 7'h1f, 1'b1, 1'b0, 2'h0, 6'h00, 8'h00);
    chk("copy_wr_count", 16'(wr_n - n0), 16'h0001);
    chk("copy_wr_addr", wr_addr, 16'h001f);
    chk("copy_wr_data", {8'h0, wr_data}, 16'h0000);
    regs("copy_self");
    macc = 8'hff;
    issue(DMV_OP_LOAD_ACC, 7'h00, 1'b0, 1'b0, 2'h0, 6'h00, 8'hff);
    regs("lit_ff");
    n0 = wr_n;
    issue(DMV_OP_COPY_FILE, 7'h7f, 1'b0, 1'b0, 2'h0, 6'h00, 8'h00);
    macc  = memv(16'h007f);
    mflag = 1'b0;
    chk("copy_rd_addr", rd_addr, 16'h007f);
    chk("copy_no_write", 16'(wr_n - n0), 16'h0000);
    regs("copy_acc");
    macc = 8'h00;
    issue(DMV_OP_LOAD_ACC, 7'h00, 1'b0, 1'b0, 2'h0, 6'h00, 8'h00);
    regs("lit_00");
    $display("test copy and literal done");

    // bank takes five bits, page seven, flags untouched
    issue(DMV_OP_LOAD_BANK, 7'h00, 1'b0, 1'b0, 2'h0, 6'h00, 8'hff);
    chk("bank_1f", {11'h0, bank}, 16'h001f);
    issue(DMV_OP_LOAD_PAGE, 7'h00, 1'b0, 1'b0, 2'h0, 6'h00, 8'hff);
    chk("page_7f", {9'h0, page}, 16'h007f);
    issue(DMV_OP_LOAD_BANK, 7'h00, 1'b0, 1'b0, 2'h0, 6'h00, 8'h6a);
    chk("bank_0a", {11'h0, bank}, 16'h000a);
    issue(DMV_OP_LOAD_PAGE, 7'h00, 1'b0, 1'b0, 2'h0, 6'h00, 8'h95);
    chk("page_15", {9'h0, page}, 16'h0015);
    regs("bank_page");
    macc = 8'ha5;
    issue(DMV_OP_LOAD_ACC, 7'h00, 1'b0, 1'b0, 2'h0, 6'h00, 8'ha5);
    n0 = wr_n;
    issue(DMV_OP_STORE_ACC, 7'h55, 1'b0, 1'b0, 2'h0, 6'h00, 8'h00);
    chk("store_count", 16'(wr_n - n0), 16'h0001);
    chk("store_addr", wr_addr, 16'h0055);
    chk("store_data", {8'h0, wr_data}, 16'h00a5);
    regs("store");
    $display("test bank page store done");

    ind(1'b0, 1'b0, 2'h0, 6'h00);
    ind(1'b0, 1'b0, 2'h1, 6'h00);
    ind(1'b0, 1'b0, 2'h1, 6'h00);
    ind(1'b0, 1'b0, 2'h2, 6'h00);
    ind(1'b1, 1'b0, 2'h3, 6'h00);
    ind(1'b1, 1'b0, 2'h2, 6'h00);
    ind(1'b1, 1'b0, 2'h1, 6'h00);
    ind(1'b0, 1'b1, 2'h0, 6'h1f);
    ind(1'b0, 1'b1, 2'h3, 6'h20);
    ind(1'b1, 1'b1, 2'h1, 6'h3f);
    $display("test indirect done");

    // a strobe that arrives while a read is in flight is dropped
    @(posedge clk);
    ivalid <= 1'b1;
    iop    <= DMV_OP_COPY_FILE;
    ifile  <= 7'h7f;
    idest  <= 1'b0;
    @(posedge clk);
    iop    <= DMV_OP_LOAD_ACC;
    ilit   <= 8'h3c;
    @(posedge clk);
    ivalid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    macc  = memv(16'h007f);
    mflag = 1'b0;
    chk("busy_drop_acc", {8'h0, acc}, {8'h0, macc});
    regs("busy_drop");
    $display("test busy strobe done");
    report_and_stop();
  end
endmodule // dmv_core_test
